// *** shared/asb_defs.svh ***
// Purpose: Offsets, field positions, reset values and counts of the audio buffer block.
// Assumes: Byte addresses on a 16-bit register address.
// Notes:   Included by every file that uses these constants; the guard keeps it to one copy.
`ifndef ASB_DEFS_SVH
`define ASB_DEFS_SVH
`define ASB_OFF_TX_STATUS  16'hEB04
`define ASB_OFF_RX_STATUS  16'hEB08
`define ASB_OFF_DATA       16'hEB0C
`define ASB_BIT_HIT        10
`define ASB_BIT_OVR        9
`define ASB_BIT_UND        8
`define ASB_CNT_MSB        5
`define ASB_TX_STATUS_RST  32'h00000020
`define ASB_RX_STATUS_RST  32'h00000000
`define ASB_DEPTH          32
`define ASB_PTR_W          5
`define ASB_CNT_W          6
`define ASB_WORD_W         32
`define ASB_DEPTH_CNT      6'h20
`define ASB_LVL_SEL0       6'h10
`define ASB_LVL_SEL1       6'h08
`define ASB_LVL_SEL2       6'h18
`define ASB_LVL_NEVER      6'h21
`define ASB_SLOT_LAST      5'h1F
`define ASB_MCLK_PERIOD_NS 8
`define ASB_ENA_HOLD_NS    16
`define ASB_ENA_HOLD_CYC   ((`ASB_ENA_HOLD_NS + `ASB_MCLK_PERIOD_NS - 1) / `ASB_MCLK_PERIOD_NS)
`define ASB_WSEL_16        2'h0
`define ASB_WSEL_18        2'h1
`define ASB_WSEL_20        2'h2
`define ASB_WSEL_24        2'h3
`endif

// *** shared/asb_pkg.sv ***
// Purpose: Types shared by the audio buffer block.
// Assumes: Constants come from the guarded header.
// Notes:   One state struct per clock domain.
`include "asb_defs.svh"
package asb_pkg;
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_RUN  = 2'b01
    } asb_link_state_t;

    typedef struct packed {
        logic [`ASB_DEPTH-1:0][`ASB_WORD_W-1:0] tx_mem;
        logic [`ASB_DEPTH-1:0][`ASB_WORD_W-1:0] rx_mem;
        logic [`ASB_PTR_W-1:0]  tx_wp;
        logic [`ASB_PTR_W-1:0]  tx_rp;
        logic [`ASB_CNT_W-1:0]  tx_cnt;
        logic [`ASB_PTR_W-1:0]  rx_wp;
        logic [`ASB_PTR_W-1:0]  rx_rp;
        logic [`ASB_CNT_W-1:0]  rx_cnt;
        logic [`ASB_WORD_W-1:0] tx_hold;
        logic                   hold_full;
        logic                   load_tog;
        logic                   tx_ovr;
        logic                   tx_und;
        logic                   rx_ovr;
        logic                   rx_und;
        logic [2:0]             take_sy;
        logic [2:0]             miss_sy;
        logic [2:0]             rxw_sy;
        logic [`ASB_WORD_W-1:0] rdata;
    } asb_core_t;

    typedef struct packed {
        asb_link_state_t        state;
        logic [1:0]             rst_sy;
        logic [1:0]             txen_sy;
        logic [1:0]             rxen_sy;
        logic [1:0]             tload_sy;
        logic [1:0]             sdi_sy;
        logic                   tseen;
        logic                   take_tog;
        logic                   miss_tog;
        logic                   rx_tog;
        logic                   bclk;
        logic                   lrclk;
        logic                   sdo;
        logic [`ASB_PTR_W-1:0]  bitcnt;
        logic [`ASB_WORD_W-1:0] tx_shift;
        logic [`ASB_WORD_W-1:0] rx_shift;
        logic [`ASB_WORD_W-1:0] rx_word;
    } asb_link_t;
endpackage

// *** verilog/asb_audio_buffer.sv ***
// Purpose: Buffer side of a serial audio port: transmit and receive buffers, status and serial link.
// Assumes: Control bits come from an outside control register on mclk; link_clk is a free clock.
// Notes:   One bit period is two link_clk cycles; each channel slot is 32 bit periods.
// Summary of operation
// R1 - Transmit hit bit 10 is set while free entries meet the transmit threshold.
// R2 - Writing data while transmit buffer full sets bit 9; status read clears it.
// R3 - Serial word needed with transmit buffer empty sets bit 8; status read clears it.
// R4 - Transmit status bits 5:0 show free entries, resetting to 32.
// R5 - Receive hit bit 10 is set while stored words meet the receive threshold.
// R6 - Serial word arriving with receive buffer full sets bit 9; status read clears it.
// R7 - Reading data with receive buffer empty sets bit 8; status read clears it.
// R8 - Receive status bits 5:0 show stored words, resetting to zero.
// R9 - Writing the data register pushes the word into the transmit buffer.
// R10 - Software writes left then right samples alternately while transmitting.
// R11 - Reading the data register pops and returns the oldest received word.
// R12 - Received words come out left first, then right, repeating.
// R13 - Samples are left aligned with zero padding in the low bits.
// R14 - Both buffers are 32 words deep.
// R15 - Receive threshold settings 0, 1, 2 select fill levels; 3 never hits.
// R16 - Transmit threshold settings 0, 1, 2 select free levels; 3 never hits.
// R17 - Clearing an enable resets that direction; enables are held two mclk cycles.
// R18 - With both enables clear, bit clock and word select stop toggling.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "asb_defs.svh"
module asb_audio_buffer (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    // Register port
    input  wire logic [15:0]                  reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [31:0]                  reg_rdata,
    // Control from the port control register
    input  wire logic                         tx_enable,
    input  wire logic                         rx_enable,
    input  wire logic [1:0]                   tx_threshold,
    input  wire logic [1:0]                   rx_threshold,
    input  wire logic [1:0]                   width_sel,
    // Serial link
    input  wire logic                         link_clk,
    input  wire logic                         sdata_in,
    output logic                              sdata_out,
    output logic                              bclk_out,
    output logic                              lrclk_out
);
    import asb_pkg::*;

    asb_core_t st;
    asb_core_t next_st;
    asb_link_t lk;
    asb_link_t next_lk;

    // Threshold level for a 2-bit setting; the reserved code can never be met.
    function automatic logic [`ASB_CNT_W-1:0] thr_level(input logic [1:0] sel);
        logic [`ASB_CNT_W-1:0] lvl;
        lvl = `ASB_LVL_NEVER;
        unique case (sel)
            2'h0: lvl = `ASB_LVL_SEL0;
            2'h1: lvl = `ASB_LVL_SEL1;
            2'h2: lvl = `ASB_LVL_SEL2;
            2'h3: lvl = `ASB_LVL_NEVER;
        endcase
        return lvl;
    endfunction

    // Keeps the sample bits in the top of the word and zeros the padding below.
    function automatic logic [`ASB_WORD_W-1:0] left_align(input logic [`ASB_WORD_W-1:0] w,
                                                          input logic [1:0]             sel);
        logic [`ASB_WORD_W-1:0] m;
        m = 32'hFFFF0000;
        unique case (sel)
            `ASB_WSEL_16: m = 32'hFFFF0000;
            `ASB_WSEL_18: m = 32'hFFFFC000;
            `ASB_WSEL_20: m = 32'hFFFFF000;
            `ASB_WSEL_24: m = 32'hFFFFFF00;
        endcase
        return w & m;
    endfunction

    logic                  take_ev;
    logic                  miss_ev;
    logic                  rxw_ev;
    logic                  tx_push;
    logic                  tx_load;
    logic                  rx_pop;
    logic                  tx_full;
    logic                  rx_full;
    logic [`ASB_CNT_W-1:0] tx_free;
    logic                  tx_hit;
    logic                  rx_hit;
    logic                  rd_tx_stat;
    logic                  rd_rx_stat;
    logic                  rd_data;
    logic                  wr_data;

    always_comb begin
        next_st = st;
        next_st.take_sy = {st.take_sy[1:0], lk.take_tog};
        next_st.miss_sy = {st.miss_sy[1:0], lk.miss_tog};
        next_st.rxw_sy  = {st.rxw_sy[1:0], lk.rx_tog};
        take_ev    = st.take_sy[1] ^ st.take_sy[2];
        miss_ev    = st.miss_sy[1] ^ st.miss_sy[2];
        rxw_ev     = st.rxw_sy[1] ^ st.rxw_sy[2];
        rd_tx_stat = reg_rd && (reg_addr == `ASB_OFF_TX_STATUS);
        rd_rx_stat = reg_rd && (reg_addr == `ASB_OFF_RX_STATUS);
        rd_data    = reg_rd && (reg_addr == `ASB_OFF_DATA);
        wr_data    = reg_wr && (reg_addr == `ASB_OFF_DATA);
        tx_full    = (st.tx_cnt == `ASB_DEPTH_CNT); // R14
        rx_full    = (st.rx_cnt == `ASB_DEPTH_CNT); // R14
        tx_free    = `ASB_DEPTH_CNT - st.tx_cnt; // R4
        tx_hit     = tx_enable && (tx_free >= thr_level(tx_threshold)); // R1 R16
        rx_hit     = rx_enable && (st.rx_cnt >= thr_level(rx_threshold)); // R5 R15
        tx_push    = wr_data && tx_enable && !tx_full;
        tx_load    = tx_enable && !st.hold_full && (st.tx_cnt != '0);
        rx_pop     = rd_data && rx_enable && (st.rx_cnt != '0);

        // Transmit buffer: push from software, pop into the hold word for the link.
        if (tx_push) begin
            next_st.tx_mem[st.tx_wp] = reg_wdata; // R9
            next_st.tx_wp = st.tx_wp + 1'b1;
        end
        if (take_ev) begin
            next_st.hold_full = 1'b0;
        end
        if (tx_load) begin
            next_st.tx_hold   = left_align(st.tx_mem[st.tx_rp], width_sel); // R13
            next_st.tx_rp     = st.tx_rp + 1'b1;
            next_st.hold_full = 1'b1;
            next_st.load_tog  = ~st.load_tog;
        end
        next_st.tx_cnt = st.tx_cnt + {5'h0, tx_push} - {5'h0, tx_load};
        // Set wins over the clear of a status read in the same cycle.
        next_st.tx_ovr = (st.tx_ovr && !rd_tx_stat) || (wr_data && tx_enable && tx_full); // R2
        next_st.tx_und = (st.tx_und && !rd_tx_stat) || (miss_ev && tx_enable); // R3

        // Receive buffer: push from the link, pop by software.
        if (rxw_ev && rx_enable && !rx_full) begin
            next_st.rx_mem[st.rx_wp] = left_align(lk.rx_word, width_sel); // R13
            next_st.rx_wp = st.rx_wp + 1'b1;
        end
        if (rx_pop) begin
            next_st.rx_rp = st.rx_rp + 1'b1; // R11
        end
        next_st.rx_cnt = st.rx_cnt + {5'h0, (rxw_ev && rx_enable && !rx_full)} - {5'h0, rx_pop};
        next_st.rx_ovr = (st.rx_ovr && !rd_rx_stat) || (rxw_ev && rx_enable && rx_full); // R6
        next_st.rx_und = (st.rx_und && !rd_rx_stat) || (rd_data && rx_enable && (st.rx_cnt == '0)); // R7

        // Read data stands for the one cycle after the strobe; other reads give zero.
        next_st.rdata = '0;
        if (rd_tx_stat) begin
            next_st.rdata[`ASB_BIT_HIT] = tx_hit; // R1
            next_st.rdata[`ASB_BIT_OVR] = st.tx_ovr; // R2
            next_st.rdata[`ASB_BIT_UND] = st.tx_und; // R3
            next_st.rdata[`ASB_CNT_MSB:0] = tx_free; // R4
        end else if (rd_rx_stat) begin
            next_st.rdata[`ASB_BIT_HIT] = rx_hit; // R5
            next_st.rdata[`ASB_BIT_OVR] = st.rx_ovr; // R6
            next_st.rdata[`ASB_BIT_UND] = st.rx_und; // R7
            next_st.rdata[`ASB_CNT_MSB:0] = st.rx_cnt; // R8
        end else if (rx_pop) begin
            next_st.rdata = st.rx_mem[st.rx_rp]; // R11
        end

        // A cleared enable holds its direction in reset; the toggles are kept so the link stays in step.
        if (!tx_enable) begin
            next_st.tx_wp     = '0; // R17
            next_st.tx_rp     = '0;
            next_st.tx_cnt    = '0;
            next_st.hold_full = 1'b0;
            next_st.tx_ovr    = 1'b0;
            next_st.tx_und    = 1'b0;
        end
        if (!rx_enable) begin
            next_st.rx_wp  = '0; // R17
            next_st.rx_rp  = '0;
            next_st.rx_cnt = '0;
            next_st.rx_ovr = 1'b0;
            next_st.rx_und = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Link domain. Words cross by toggles; the hold and received words stay still for a
    // whole slot, far longer than the toggle takes to arrive: three mclk cycles in, two link_clk cycles out.
    logic                   lk_run;
    logic [`ASB_WORD_W-1:0] lk_word;

    always_comb begin
        next_lk = lk;
        lk_word = '0;
        next_lk.rst_sy   = {lk.rst_sy[0], rst_n};
        next_lk.txen_sy  = {lk.txen_sy[0], tx_enable};
        next_lk.rxen_sy  = {lk.rxen_sy[0], rx_enable};
        next_lk.tload_sy = {lk.tload_sy[0], st.load_tog};
        next_lk.sdi_sy   = {lk.sdi_sy[0], sdata_in};
        lk_run = lk.txen_sy[1] || lk.rxen_sy[1];
        unique case (lk.state)
            LK_IDLE: begin
                next_lk.bclk   = 1'b0; // R18
                next_lk.lrclk  = 1'b0;
                next_lk.bitcnt = '0;
                next_lk.sdo    = 1'b0;
                next_lk.tseen  = lk.tload_sy[1];
                if (lk_run) begin
                    next_lk.state = LK_RUN;
                end
            end
            LK_RUN: begin
                next_lk.bclk = ~lk.bclk;
                if (!lk.bclk) begin
                    if (lk.bitcnt == '0) begin
                        if (lk.txen_sy[1] && (lk.tload_sy[1] != lk.tseen)) begin
                            lk_word          = st.tx_hold;
                            next_lk.tseen    = lk.tload_sy[1];
                            next_lk.take_tog = ~lk.take_tog;
                        end else if (lk.txen_sy[1]) begin
                            next_lk.miss_tog = ~lk.miss_tog; // R3
                        end else begin
                            next_lk.tseen = lk.tload_sy[1];
                        end
                        next_lk.sdo      = lk_word[`ASB_WORD_W-1];
                        next_lk.tx_shift = {lk_word[`ASB_WORD_W-2:0], 1'b0};
                    end else begin
                        next_lk.sdo      = lk.tx_shift[`ASB_WORD_W-1];
                        next_lk.tx_shift = {lk.tx_shift[`ASB_WORD_W-2:0], 1'b0};
                    end
                end else begin
                    next_lk.rx_shift = {lk.rx_shift[`ASB_WORD_W-2:0], lk.sdi_sy[1]};
                    next_lk.bitcnt   = lk.bitcnt + 1'b1;
                    if (lk.bitcnt == `ASB_SLOT_LAST) begin
                        next_lk.lrclk = ~lk.lrclk; // R12
                        if (lk.rxen_sy[1]) begin
                            next_lk.rx_word = {lk.rx_shift[`ASB_WORD_W-2:0], lk.sdi_sy[1]};
                            next_lk.rx_tog  = ~lk.rx_tog;
                        end
                    end
                end
                if (!lk_run) begin
                    next_lk.state = LK_IDLE; // R18
                    next_lk.bclk  = 1'b0;
                end
            end
            default: begin
                next_lk.state = LK_IDLE;
            end
        endcase
        if (!lk.rst_sy[1]) begin
            next_lk.state    = LK_IDLE;
            next_lk.bclk     = 1'b0;
            next_lk.lrclk    = 1'b0;
            next_lk.bitcnt   = '0;
            next_lk.sdo      = 1'b0;
            next_lk.tseen    = 1'b0;
            next_lk.take_tog = 1'b0;
            next_lk.miss_tog = 1'b0;
            next_lk.rx_tog   = 1'b0;
        end
    end

    // The synchroniser stages have no reset, so the link reset needs no clock of its own.
    always_ff @(posedge link_clk) begin
        lk <= next_lk;
    end

    assign reg_rdata = st.rdata;
    assign sdata_out = lk.sdo;
    assign bclk_out  = lk.bclk;
    assign lrclk_out = lk.lrclk;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_TX_HIT: assert property (rd_tx_stat |=> reg_rdata[10] == $past(tx_hit)) // R1
        else $error("transmit hit bit wrong");
    AST_TX_OVR_SET: assert property (wr_data && tx_enable && tx_full |=> st.tx_ovr) // R2
        else $error("transmit overrun not set");
    AST_TX_OVR_CLR: assert property (rd_tx_stat && !(wr_data) ##1 (!wr_data && tx_enable) |-> !st.tx_ovr) // R2
        else $error("transmit overrun not cleared by read");
    AST_TX_UND: assert property (miss_ev && tx_enable |=> st.tx_und || !tx_enable) // R3
        else $error("transmit underrun not set");
    AST_TX_FREE: assert property (rd_tx_stat |=> reg_rdata[5:0] == 6'h20 - $past(st.tx_cnt)) // R4
        else $error("transmit free count wrong");
    AST_RX_OVR: assert property (rxw_ev && rx_enable && rx_full |=> st.rx_ovr || !rx_enable) // R6
        else $error("receive overrun not set");
    AST_RX_UND: assert property (rd_data && rx_enable && st.rx_cnt == 6'h0 |=> st.rx_und || !rx_enable) // R7
        else $error("receive underrun not set");
    AST_RX_CNT: assert property (rd_rx_stat |=> reg_rdata[5:0] == $past(st.rx_cnt)) // R8
        else $error("receive count wrong");
    AST_TX_PUSH: assert property (tx_push ##1 tx_enable |-> st.tx_mem[$past(st.tx_wp)] == $past(reg_wdata)) // R9
        else $error("written word not stored");
    AST_RX_POP: assert property (rx_pop |=> reg_rdata == $past(st.rx_mem[st.rx_rp])) // R11
        else $error("popped word wrong");
    AST_TX_DISABLE: assert property (!tx_enable |=> st.tx_cnt == 6'h0 && !st.tx_ovr) // R17
        else $error("transmit side not reset while disabled");
    AST_CNT_RANGE: assert property (st.tx_cnt <= 6'h20 && st.rx_cnt <= 6'h20) // R14
        else $error("buffer count beyond depth");
    // The stop may come in a right slot, so word select is expected back at its idle low level.
    AST_LINK_STOP: assert property (@(posedge link_clk) disable iff (!lk.rst_sy[1]) // R18
        (!lk.txen_sy[1] && !lk.rxen_sy[1]) [*2] |=> !lk.bclk && !lk.lrclk)
        else $error("link clocks toggle while both directions off");
    AST_LINK_SLOT: assert property (@(posedge link_clk) disable iff (!lk.rst_sy[1]) // R12
        lk.state == LK_RUN && lk_run && lk.bclk && lk.bitcnt == 5'h1F |=> lk.lrclk != $past(lk.lrclk))
        else $error("word select did not change at slot end");
    AST_RX_HIT: assert property (rd_rx_stat && rx_enable && rx_threshold == 2'h0 && st.rx_cnt >= 6'h10 |=> reg_rdata[10]) // R5 R15
        else $error("receive hit bit not set at half full");
    AST_TX_ALIGN: assert property (tx_load && width_sel == 2'h3 |=> st.tx_hold[7:0] == 8'h00) // R13
        else $error("transmit padding bits not zero");

    COV_TX_FLOW: cover property (tx_push ##[1:20] tx_load);
    COV_RX_FLOW: cover property (rxw_ev && rx_enable ##[1:50] rx_pop);
    COV_TX_OVR: cover property (wr_data && tx_enable && tx_full);
    COV_RX_HIT: cover property (rd_rx_stat && rx_hit);
endmodule

// *** testbench/asb_codec_model.sv ***
// Purpose: Behavioural audio codec at the far end of the serial link.
// Assumes: The port changes its bits with the rising bit clock, so they are taken on the falling one.
// Notes:   The port's input lags one bit, so this codec leads its words by one bit.
`timescale 1ns/1ps
module asb_codec_model #(
    parameter logic [31:0] LEFT_WORD  = 32'hC35A96F0,
    parameter logic [31:0] RIGHT_WORD = 32'h3CA5690F
) (
    // Link clock, used only to see the bit clock stop
    input  wire logic link_clk,
    // Serial link
    input  wire logic bclk_out,
    input  wire logic lrclk_out,
    input  wire logic sdata_out,
    output logic      sdata_in
);
    logic [31:0] got_words[$];
    logic [31:0] shreg  = 32'h00000000;
    logic [31:0] cur;
    logic [4:0]  pos    = 5'h1F;
    logic [5:0]  nxt;
    logic        lr_q   = 1'b0;
    logic        bclk_q = 1'b0;
    logic [2:0]  still  = 3'h0;

    initial sdata_in = 1'b0;

    // Outside frames the line is not held, so it toggles rather than keep a stale bit.
    always @(posedge link_clk) begin
        if (bclk_out !== bclk_q) begin
            still = 3'h0;
        end else if (still != 3'h7) begin
            still = still + 3'h1;
        end
        bclk_q = bclk_out;
        if (still > 3'h4) begin
            pos = 5'h1F;
            lr_q = 1'b0;
            sdata_in <= ~sdata_in;
        end
    end

    always @(posedge bclk_out) begin
        if (lrclk_out !== lr_q) begin
            lr_q = lrclk_out;
            pos = 5'h00;
        end else begin
            pos = pos + 5'h01;
        end
    end

    // Taking the bit on the rising edge would race the port's own update of the line.
    always @(negedge bclk_out) begin
        shreg = {shreg[30:0], sdata_out};
        if (pos == 5'h1F) begin
            got_words.push_back(shreg);
        end
        nxt = {1'b0, pos} + 6'h02;
        cur = (lr_q ^ nxt[5]) ? RIGHT_WORD : LEFT_WORD;
        sdata_in <= cur[5'h1F - nxt[4:0]];
    end
endmodule

// *** testbench/asb_audio_buffer_tb.sv ***
// Purpose: Self-checking bench of the audio buffer block against a codec model.
// Assumes: Transmit uses 24-bit samples and receive 18-bit samples, so the padding differs.
// Notes:   Reset is held 8 cycles; the link side still sees two of its edges inside it.
`timescale 1ns/1ps
`include "asb_defs.svh"
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module asb_audio_buffer_tb;
    import asb_pkg::*;
    localparam logic [31:0] LW   = 32'hC35A96F0;
    localparam logic [31:0] RW   = 32'h3CA5690F;
    localparam logic [31:0] MASK = 32'hFFFFFF00;
    int          err_count  = 0;
    int          num_checks = 0;
    logic        mclk       = 1'b0;
    logic        link_clk   = 1'b0;
    logic        rst_n      = 1'b0;
    logic [15:0] reg_addr   = 16'h0000;
    logic [31:0] reg_wdata  = 32'h00000000;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic [31:0] reg_rdata;
    logic        tx_enable  = 1'b0;
    logic        rx_enable  = 1'b0;
    logic [1:0]  tx_thr     = 2'h0;
    logic [1:0]  rx_thr     = 2'h0;
    logic [1:0]  wsel       = `ASB_WSEL_24;
    logic        sdata_in;
    logic        sdata_out;
    logic        bclk_out;
    logic        lrclk_out;

    initial forever #4 mclk = ~mclk;
    initial begin
        #3;
        forever #16 link_clk = ~link_clk;
    end

    asb_audio_buffer dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_enable(tx_enable),
        .rx_enable(rx_enable), .tx_threshold(tx_thr), .rx_threshold(rx_thr), .width_sel(wsel),
        .link_clk(link_clk), .sdata_in(sdata_in), .sdata_out(sdata_out), .bclk_out(bclk_out),
        .lrclk_out(lrclk_out));
    asb_codec_model #(.LEFT_WORD(LW), .RIGHT_WORD(RW)) codec (.link_clk(link_clk),
        .bclk_out(bclk_out), .lrclk_out(lrclk_out), .sdata_out(sdata_out), .sdata_in(sdata_in));

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    function automatic logic [31:0] tx_word(input int i);
        return 32'hA5000077 ^ (32'(i) << 12);
    endfunction
    task automatic t_idle();
        repeat (16) @(posedge mclk);
        repeat (32) begin
            @(posedge mclk);
            `CHK({bclk_out, lrclk_out}, 2'b00);
        end
    endtask
    task automatic t_reset();
        logic [31:0] d;
        rd(`ASB_OFF_TX_STATUS, d);
        `CHK(d, `ASB_TX_STATUS_RST);
        rd(`ASB_OFF_RX_STATUS, d);
        `CHK(d, `ASB_RX_STATUS_RST);
        rd(16'hEB10, d);
        `CHK(d, 32'h00000000);
        t_idle();
    endtask
    task automatic t_tx();
        logic [31:0] d;
        @(posedge mclk) tx_enable <= 1'b1;
        repeat (600) @(posedge mclk);
        rd(`ASB_OFF_TX_STATUS, d);
        `CHK(d, 32'h00000520);
        rd(`ASB_OFF_TX_STATUS, d);
        `CHK(d, 32'h00000420);
        codec.got_words.delete();
        for (int i = 0; i < 6; i++) wr(`ASB_OFF_DATA, tx_word(i));
        repeat (2600) @(posedge mclk);
        while (codec.got_words.size() > 0 && codec.got_words[0] === 32'h0) void'(codec.got_words.pop_front());
        `CHK(codec.got_words.size() >= 6, 1'b1);
        for (int i = 0; i < 6 && i < codec.got_words.size(); i++) begin
            `CHK(codec.got_words[i], tx_word(i) & MASK);
        end
        for (int i = 0; i < 20; i++) wr(`ASB_OFF_DATA, tx_word(i));
        for (int t = 0; t < 4; t++) begin
            @(posedge mclk) tx_thr <= 2'(t);
            rd(`ASB_OFF_TX_STATUS, d);
            `CHK(d[10], 1'(t == 1));
        end
        @(posedge mclk) tx_thr <= 2'h0;
        for (int i = 0; i < 20; i++) wr(`ASB_OFF_DATA, tx_word(i));
        rd(`ASB_OFF_TX_STATUS, d);
        `CHK({d[9], d[5:1]}, 6'h20);
        rd(`ASB_OFF_TX_STATUS, d);
        `CHK(d[9], 1'b0);
        // Enables are held well past two cycles after every change.
        // The link must stand still long enough for the codec to start the next run on a fresh frame.
        @(posedge mclk) tx_enable <= 1'b0;
        repeat (48) @(posedge mclk);
        `CHK({bclk_out, lrclk_out}, 2'b00);
        rd(`ASB_OFF_TX_STATUS, d);
        `CHK(d, 32'h00000020);
    endtask
    task automatic t_rx();
        logic [31:0] d;
        @(posedge mclk) begin
            rx_enable <= 1'b1;
            wsel      <= `ASB_WSEL_18;
        end
        repeat (3) @(posedge mclk);
        rd(`ASB_OFF_DATA, d);
        `CHK(d, 32'h00000000);
        rd(`ASB_OFF_RX_STATUS, d);
        `CHK(d, 32'h00000100);
        rd(`ASB_OFF_RX_STATUS, d);
        `CHK(d, 32'h00000000);
        repeat (3600) @(posedge mclk);
        // The very first left word has no leading bit before the link started.
        rd(`ASB_OFF_DATA, d);
        for (int i = 1; i < 6; i++) begin
            rd(`ASB_OFF_DATA, d);
            `CHK(d, ((i % 2) ? RW : LW) & 32'hFFFFC000);
        end
        repeat (9000) @(posedge mclk);
        rd(`ASB_OFF_RX_STATUS, d);
        `CHK(d, 32'h00000620);
        for (int t = 0; t < 4; t++) begin
            @(posedge mclk) rx_thr <= 2'(t);
            rd(`ASB_OFF_RX_STATUS, d);
            `CHK(d[10], 1'(t != 3));
        end
        @(posedge mclk) rx_enable <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(`ASB_OFF_RX_STATUS, d);
        `CHK(d, 32'h00000000);
    endtask
    task automatic summarize();
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        $display("mismatch at %0t: run did not finish", $time);
        summarize();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_idle();
        summarize();
    end
endmodule
